// ===== dpplat_core.sv
// Two-channel probe unit latching the feedback position on probe edges.
// Assumes a register port with one-cycle strobes and same-clock feedback.
//
// How it works
// (R01) Two independent probe channels each latch position on both edges.
// (R02) Probe polarity applies only while the control mode value is 9.
// (R03) Polarity value 0 inverts both, 1 probe two, 2 probe one, 3 none.
// (R04) With control mode not 9 the polarity value selects pulse input mode.
// (R05) Polarity bit 0 belongs to probe one and bit 1 to probe two.
// (R06) Control word low byte steers probe one and high byte probe two.
// (R07) Single mode accepts only rising edges, continuous mode both edges.
// (R08) A write that changes enable, source or edge settings clears counters and flags.
// (R09) Probe one level shows in input status bit 26, probe two in bit 27.
// (R10) Four signed 32-bit latched positions, one per probe and edge.
// (R11) Four unsigned 32-bit edge counters, one per probe and edge.
// (R12) Control byte: enable 0, mode 1, source 2, rising 4, falling 5.
// (R13) Status byte: enable 0, rising done 1, falling done 2, per probe.
// (R14) In single mode software re-enables the probe to capture again.
// (R15) In continuous mode each latch holds until the next trigger.
// (R16) Inputs are synchronised and each hit latches and counts at once.
// (R17) A disabled probe changes no position, counter or flag.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module dpplat_core
   import dpplat_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [15:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [31:0] rdData,
   input wire logic probeInputOne,
   input wire logic probeInputTwo,
   input wire logic indexPulse,
   input wire logic signed [31:0] feedbackPos,
   output logic [1:0] pulseInputMode,
   output logic irq
);
   logic [2:0] syncA_reg;
   logic [2:0] syncB_reg;
   logic [15:0] ctrlMode_reg;
   logic [1:0] polarity_reg;
   logic [15:0] ctrl_reg;
   logic [3:0] irqStat_reg;
   logic [3:0] irqStat_next;
   logic [3:0] irqMask_reg;
   logic [3:0] irqMask_next;
   logic [31:0] rdData_reg;
   logic [31:0] rdMux;
   logic [1:0] pulseMode_reg;
   logic irq_reg;
   logic probeModeOn;
   logic [1:0] riseHit;
   logic [1:0] fallHit;
   logic [1:0] cfgWr;
   logic [1:0] riseDone;
   logic [1:0] fallDone;
   logic signed [31:0] posRise [2];
   logic signed [31:0] posFall [2];
   logic [31:0] cntRise [2];
   logic [31:0] cntFall [2];
   logic [15:0] statusWord;
   logic ctrlWr;

   assign ctrlWr = wrEn && addr == OFS_CTRL;
   // (R02) polarity gate
   assign probeModeOn = ctrlMode_reg == PROBE_CTRL_MODE;

   // (R16) input synchroniser
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         syncA_reg <= 3'h0;
         syncB_reg <= 3'h0;
      end
      else
      begin
         syncA_reg <= {indexPulse, probeInputTwo, probeInputOne};
         syncB_reg <= syncA_reg;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ctrlMode_reg <= CTRL_MODE_RST;
         polarity_reg <= POLARITY_RST;
         ctrl_reg <= CTRL_RST;
         irqMask_reg <= IRQ_MASK_RST;
      end
      else if (wrEn)
      begin
         if (addr == OFS_CTRL_MODE)
            ctrlMode_reg <= wrData[15:0];
         if (addr == OFS_POLARITY)
            polarity_reg <= wrData[1:0];
         // (R06) control word store
         if (addr == OFS_CTRL)
            ctrl_reg <= wrData[15:0];
         irqMask_reg <= irqMask_next;
      end
   end

   always_comb
   begin
      irqMask_next = irqMask_reg;
      if (wrEn && addr == OFS_IRQ_MASK)
         irqMask_next = wrData[3:0];
   end

   // (R04) pulse input mode select
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         pulseMode_reg <= 2'h0;
      else if (probeModeOn)
         pulseMode_reg <= 2'h0;
      else
         pulseMode_reg <= polarity_reg;
   end

   // (R01) one channel per probe
   for (genvar g = 0; g < 2; g++)
   begin : probe
      logic [7:0] cb;
      logic [7:0] newCb;
      logic inv;
      logic lvl;
      logic prev_reg;
      logic armed_reg;

      // (R12) control byte fields
      assign cb = ctrl_reg[g * BYTE_STRIDE +: 8];
      assign newCb = wrData[g * BYTE_STRIDE +: 8];
      // (R03) (R05) bit clear means inverted
      assign inv = probeModeOn && !polarity_reg[g];
      assign lvl = cb[CB_SRC] ? syncB_reg[2] : (syncB_reg[g] ^ inv);
      // (R08) settings change detect
      assign cfgWr[g] = ctrlWr && ((newCb & CB_CFG_MASK) != (cb & CB_CFG_MASK));
      // (R07) (R17) valid edges only
      assign riseHit[g] = cb[CB_EN] && cb[CB_RISE] && lvl && !prev_reg &&
         (cb[CB_MODE] || armed_reg) && !cfgWr[g];
      assign fallHit[g] = cb[CB_EN] && cb[CB_FALL] && !lvl && prev_reg &&
         cb[CB_MODE] && !cfgWr[g];

      always_ff @(posedge sys_clk)
      begin
         if (!rst_n)
            prev_reg <= 1'b0;
         else
            prev_reg <= lvl;
      end

      // (R14) rearm on enable
      always_ff @(posedge sys_clk)
      begin
         if (!rst_n)
            armed_reg <= 1'b0;
         else if (ctrlWr && newCb[CB_EN] && !cb[CB_EN])
            armed_reg <= 1'b1;
         else if (riseHit[g])
            armed_reg <= 1'b0;
      end

      // (R10) (R15) (R16) position latch
      always_ff @(posedge sys_clk)
      begin
         if (!rst_n)
         begin
            posRise[g] <= 32'sh0;
            posFall[g] <= 32'sh0;
         end
         else
         begin
            if (riseHit[g])
               posRise[g] <= feedbackPos;
            if (fallHit[g])
               posFall[g] <= feedbackPos;
         end
      end

      // (R08) (R11) edge counters
      always_ff @(posedge sys_clk)
      begin
         if (!rst_n || cfgWr[g])
         begin
            cntRise[g] <= 32'h0;
            cntFall[g] <= 32'h0;
         end
         else
         begin
            if (riseHit[g])
               cntRise[g] <= cntRise[g] + 32'h1;
            if (fallHit[g])
               cntFall[g] <= cntFall[g] + 32'h1;
         end
      end

      // (R13) executed flags
      always_ff @(posedge sys_clk)
      begin
         if (!rst_n || cfgWr[g])
         begin
            riseDone[g] <= 1'b0;
            fallDone[g] <= 1'b0;
         end
         else
         begin
            if (riseHit[g])
               riseDone[g] <= 1'b1;
            if (fallHit[g])
               fallDone[g] <= 1'b1;
         end
      end

      // (R13) status byte layout
      always_comb
      begin
         statusWord[g * BYTE_STRIDE +: 8] = 8'h0;
         statusWord[g * BYTE_STRIDE + SB_EN] = cb[CB_EN];
         statusWord[g * BYTE_STRIDE + SB_RISE] = riseDone[g];
         statusWord[g * BYTE_STRIDE + SB_FALL] = fallDone[g];
      end
   end

   // Latch events are sticky; a read clears them but a new event wins.
   always_comb
   begin
      irqStat_next = irqStat_reg;
      if (rdEn && addr == OFS_IRQ_STATUS)
         irqStat_next = 4'h0;
      irqStat_next = irqStat_next | {fallHit[1], riseHit[1], fallHit[0],
         riseHit[0]};
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         irqStat_reg <= 4'h0;
         irq_reg <= 1'b0;
      end
      else
      begin
         irqStat_reg <= irqStat_next;
         irq_reg <= |(irqStat_next & irqMask_next);
      end
   end

   always_comb
   begin
      rdMux = 32'h0;
      case (addr)
         OFS_CTRL_MODE: rdMux = {16'h0, ctrlMode_reg};
         OFS_POLARITY: rdMux = {30'h0, polarity_reg};
         OFS_CTRL: rdMux = {16'h0, ctrl_reg};
         OFS_STATUS: rdMux = {16'h0, statusWord};
         OFS_POS_RISE1: rdMux = posRise[0];
         OFS_POS_FALL1: rdMux = posFall[0];
         OFS_POS_RISE2: rdMux = posRise[1];
         OFS_POS_FALL2: rdMux = posFall[1];
         OFS_CNT_RISE1: rdMux = cntRise[0];
         OFS_CNT_FALL1: rdMux = cntFall[0];
         OFS_CNT_RISE2: rdMux = cntRise[1];
         OFS_CNT_FALL2: rdMux = cntFall[1];
         // (R09) probe levels
         OFS_DIN_STATUS: rdMux[DIN_PROBE_BIT +: 2] = syncB_reg[1:0];
         OFS_IRQ_STATUS: rdMux = {28'h0, irqStat_reg};
         OFS_IRQ_MASK: rdMux = {28'h0, irqMask_reg};
         default: rdMux = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         rdData_reg <= 32'h0;
      else if (rdEn)
         rdData_reg <= rdMux;
      else
         rdData_reg <= 32'h0;
   end

   assign rdData = rdData_reg;
   assign irq = irq_reg;
   assign pulseInputMode = pulseMode_reg;

   sequence s_single_hit;
      riseHit[1] && !ctrl_reg[BYTE_STRIDE + CB_MODE] && !wrEn;
   endsequence

   sequence s_no_writes;
      (!wrEn) [*3];
   endsequence

   a_rise_latch_pos: assert property ( // (R16)
      @(posedge sys_clk) disable iff (!rst_n)
      riseHit[0] |=> posRise[0] == $past(feedbackPos))
      else $error("rising latch missed the feedback position");

   a_rise_count_step: assert property ( // (R11)
      @(posedge sys_clk) disable iff (!rst_n)
      riseHit[1] |=> cntRise[1] == $past(cntRise[1]) + 32'h1)
      else $error("rising counter did not step by one");

   a_fall_cont_only: assert property ( // (R07)
      @(posedge sys_clk) disable iff (!rst_n)
      fallHit[0] |-> ctrl_reg[CB_MODE] && !probe[0].lvl)
      else $error("falling trigger outside continuous mode");

   a_single_once: assert property ( // (R14)
      @(posedge sys_clk) disable iff (!rst_n)
      s_single_hit ##1 s_no_writes |-> !riseHit[1])
      else $error("second trigger in single mode without rearm");

   a_cfg_clears_cnt: assert property ( // (R08)
      @(posedge sys_clk) disable iff (!rst_n)
      cfgWr[0] |=> cntRise[0] == 32'h0 && cntFall[0] == 32'h0 &&
         statusWord[SB_RISE] == 1'b0)
      else $error("settings write did not clear counters");

   a_disabled_quiet: assert property ( // (R17)
      @(posedge sys_clk) disable iff (!rst_n)
      !ctrl_reg[BYTE_STRIDE + CB_EN] && !ctrlWr |=>
         $stable(cntRise[1]) && $stable(posFall[1]) && $stable(riseDone[1]))
      else $error("disabled probe changed its state");

   a_polarity_gate: assert property ( // (R02)
      @(posedge sys_clk) disable iff (!rst_n)
      !probeModeOn && !ctrl_reg[CB_SRC] |-> probe[0].lvl == syncB_reg[0])
      else $error("polarity applied outside probe control mode");

   a_pulse_mode_sel: assert property ( // (R04)
      @(posedge sys_clk) disable iff (!rst_n)
      rst_n && !probeModeOn && $stable(polarity_reg) |=>
         pulseInputMode == $past(polarity_reg))
      else $error("pulse input mode not taken from polarity value");

   a_din_levels: assert property ( // (R09)
      @(posedge sys_clk) disable iff (!rst_n)
      rdEn && addr == OFS_DIN_STATUS |=>
         rdData[27:26] == $past(syncB_reg[1:0]))
      else $error("input status bits do not show probe levels");

   a_fall_latch_pos: assert property ( // (R10)
      @(posedge sys_clk) disable iff (!rst_n)
      fallHit[0] |=> posFall[0] == $past(feedbackPos))
      else $error("falling latch missed the feedback position");

   a_fall_count_step: assert property ( // (R11)
      @(posedge sys_clk) disable iff (!rst_n)
      fallHit[0] |=> cntFall[0] == $past(cntFall[0]) + 32'h1)
      else $error("falling counter did not step by one");

   a_rise_flag_set: assert property ( // (R13)
      @(posedge sys_clk) disable iff (!rst_n)
      riseHit[0] |=> statusWord[SB_RISE])
      else $error("rising latch did not set its executed flag");

   a_latch_holds: assert property ( // (R15)
      @(posedge sys_clk) disable iff (!rst_n)
      !riseHit[0] |=> $stable(posRise[0]))
      else $error("rising latch changed without a trigger");

   a_index_source: assert property ( // (R12)
      @(posedge sys_clk) disable iff (!rst_n)
      ctrl_reg[BYTE_STRIDE + CB_SRC] |-> probe[1].lvl == syncB_reg[2])
      else $error("index source not routed to probe two");

   a_irq_level: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      irq == |(irqStat_reg & irqMask_reg))
      else $error("interrupt does not follow masked status");
endmodule : dpplat_core

// ===== dpplat_pkg.sv
// Constants for the two-channel probe position latch.
// Assumes a 16-bit object index on the register port and 32-bit data.
package dpplat_pkg;
   localparam logic [15:0] OFS_CTRL_MODE = 16'h2001;
   localparam logic [15:0] OFS_POLARITY = 16'h2007;
   localparam logic [15:0] OFS_CTRL = 16'h60b8;
   localparam logic [15:0] OFS_STATUS = 16'h60b9;
   localparam logic [15:0] OFS_POS_RISE1 = 16'h60ba;
   localparam logic [15:0] OFS_POS_FALL1 = 16'h60bb;
   localparam logic [15:0] OFS_POS_RISE2 = 16'h60bc;
   localparam logic [15:0] OFS_POS_FALL2 = 16'h60bd;
   localparam logic [15:0] OFS_CNT_RISE1 = 16'h60d5;
   localparam logic [15:0] OFS_CNT_FALL1 = 16'h60d6;
   localparam logic [15:0] OFS_CNT_RISE2 = 16'h60d7;
   localparam logic [15:0] OFS_CNT_FALL2 = 16'h60d8;
   localparam logic [15:0] OFS_DIN_STATUS = 16'h60fd;
   localparam logic [15:0] OFS_IRQ_STATUS = 16'h2100;
   localparam logic [15:0] OFS_IRQ_MASK = 16'h2101;
   localparam logic [15:0] CTRL_MODE_RST = 16'h0000;
   localparam logic [15:0] PROBE_CTRL_MODE = 16'h0009;
   localparam logic [1:0] POLARITY_RST = 2'h3;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   localparam int CB_EN = 0;
   localparam int CB_MODE = 1;
   localparam int CB_SRC = 2;
   localparam int CB_RISE = 4;
   localparam int CB_FALL = 5;
   localparam logic [7:0] CB_CFG_MASK = 8'h35;
   localparam int SB_EN = 0;
   localparam int SB_RISE = 1;
   localparam int SB_FALL = 2;
   localparam int BYTE_STRIDE = 8;
   localparam int DIN_PROBE_BIT = 26;
endpackage : dpplat_pkg

// ===== dpplat_probe_model.sv
// Probe sensors and encoder index pulse facing the probe latch.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/1ns
module dpplat_probe_model
(
   input wire logic wantOne,
   input wire logic wantTwo,
   input wire logic wantIdx,
   output logic probeInputOne,
   output logic probeInputTwo,
   output logic indexPulse
);
   // Sensors switch out of step with the drive clock.
   assign #3 probeInputOne = wantOne;
   assign #3 probeInputTwo = wantTwo;
   assign #3 indexPulse = wantIdx;
endmodule : dpplat_probe_model

// ===== tb_dual_probe_position_latch.sv
// Self-checking bench for the two-channel probe position latch.
// Assumes dpplat_pkg, dpplat_core and the probe model are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_dual_probe_position_latch;
   import dpplat_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wrData = 32'h0;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic [31:0] rdData;
   logic [1:0] pulseInputMode;
   logic irq;
   logic signed [31:0] feedbackPos = 32'sh0;
   logic [2:0] want = 3'h0;
   logic probeInputOne, probeInputTwo, indexPulse;
   int errors = 0;
   int checked = 0;
   int seed = 48017;
   logic [15:0] ctrl = 16'h0, mode = 16'h0;
   logic [1:0] pol = 2'h3, armed = 2'h0, lvl = 2'h0;
   logic [3:0] irqSt = 4'h0, mask = 4'h0, done = 4'h0;
   logic [31:0] pos [4] = '{default: 32'h0};
   int cnt [4] = '{default: 0};
   logic [31:0] d;

   always #5 sys_clk = ~sys_clk;

   dpplat_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
      .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
      .probeInputOne(probeInputOne), .probeInputTwo(probeInputTwo),
      .indexPulse(indexPulse), .feedbackPos(feedbackPos),
      .pulseInputMode(pulseInputMode), .irq(irq));
   dpplat_probe_model i_probes (.wantOne(want[0]), .wantTwo(want[1]),
      .wantIdx(want[2]), .probeInputOne(probeInputOne),
      .probeInputTwo(probeInputTwo), .indexPulse(indexPulse));

   task automatic wrap_up();
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // Reference model: logical edges after polarity and source selection.
   task automatic settle();
      logic [1:0] inv;
      logic [1:0] now;
      logic [7:0] b;
      int k;
      inv = (mode == PROBE_CTRL_MODE) ? ~pol : 2'h0;
      now = {ctrl[10] ? want[2] : want[1] ^ inv[1],
             ctrl[2] ? want[2] : want[0] ^ inv[0]};
      for (int p = 0; p < 2; p++)
      begin
         b = ctrl[8*p +: 8];
         k = 2 * p + (now[p] ? 0 : 1);
         if (now[p] != lvl[p] && b[CB_EN] && b[now[p] ? CB_RISE : CB_FALL]
             && (b[CB_MODE] || (now[p] && armed[p])))
         begin
            if (!b[CB_MODE])
               armed[p] = 1'b0;
            pos[k] = feedbackPos;
            cnt[k]++;
            done[k] = 1'b1;
            irqSt[k] = 1'b1;
         end
      end
      lvl = now;
   endtask : settle

   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      logic [7:0] o;
      logic [7:0] n;
      @(posedge sys_clk);
      addr <= a;
      wrData <= v;
      wrEn <= 1'b1;
      @(posedge sys_clk);
      wrEn <= 1'b0;
      for (int p = 0; p < 2 && a == OFS_CTRL; p++)
      begin
         o = ctrl[8*p +: 8];
         n = v[8*p +: 8];
         if (((o ^ n) & CB_CFG_MASK) != 8'h0)
         begin
            cnt[2*p] = 0;
            cnt[2*p+1] = 0;
            done[2*p +: 2] = 2'h0;
         end
         if (!o[CB_EN] && n[CB_EN])
            armed[p] = 1'b1;
      end
      if (a == OFS_CTRL)
         ctrl = v[15:0];
      if (a == OFS_POLARITY)
         pol = v[1:0];
      if (a == OFS_CTRL_MODE)
         mode = v[15:0];
      if (a == OFS_IRQ_MASK)
         mask = v[3:0];
      repeat (6) @(posedge sys_clk);
      settle();
   endtask : wr

   task automatic rd(input logic [15:0] a);
      @(posedge sys_clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge sys_clk);
      rdEn <= 1'b0;
      #1 d = rdData;
   endtask : rd

   task automatic check();
      for (int k = 0; k < 4; k++)
      begin
         rd(OFS_POS_RISE1 + 16'(k));
         `CHK("position", pos[k], d)
         rd(OFS_CNT_RISE1 + 16'(k));
         `CHK("counter", 32'(cnt[k]), d)
      end
      rd(OFS_STATUS);
      `CHK("status", {21'h0, done[3:2], ctrl[8], 5'h0, done[1:0], ctrl[0]}, d)
      rd(OFS_CTRL);
      `CHK("control", {16'h0, ctrl}, d)
      rd(OFS_POLARITY);
      `CHK("polarity", {30'h0, pol}, d)
      rd(OFS_DIN_STATUS);
      `CHK("inputs", {4'h0, want[1:0], 26'h0}, d)
      `CHK("pulse mode", mode == PROBE_CTRL_MODE ? 2'h0 : pol, pulseInputMode)
      `CHK("irq", |(irqSt & mask), irq)
      rd(OFS_IRQ_STATUS);
      `CHK("irq status", {28'h0, irqSt}, d)
      irqSt = 4'h0;
   endtask : check

   task automatic pin(input int i, input logic v);
      wr(OFS_IRQ_MASK, $random(seed) & 32'hf);
      @(posedge sys_clk);
      feedbackPos <= $random(seed);
      want[i] <= v;
      repeat (8) @(posedge sys_clk);
      settle();
      check();
   endtask : pin

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      wrap_up();
   end

   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      check();
      rd(16'h1234);
      `CHK("unmapped", 32'h0, d)
      wr(OFS_POS_RISE1, 32'h5a5a);
      rd(OFS_POS_RISE1);
      `CHK("read only", 32'h0, d)
      wr(OFS_POLARITY, 32'h1);
      wr(OFS_CTRL, 32'h3133);
      for (int n = 0; n < 4; n++)
         pin(0, !n[0]);
      pin(1, 1'b1);
      pin(1, 1'b0);
      pin(1, 1'b1);
      wr(OFS_CTRL, 32'h3033);
      wr(OFS_CTRL, 32'h3133);
      pin(1, 1'b0);
      pin(1, 1'b1);
      wr(OFS_CTRL_MODE, 32'h9);
      check();
      pin(0, 1'b1);
      wr(OFS_POLARITY, 32'h2);
      check();
      pin(0, 1'b0);
      wr(OFS_CTRL, 32'h3137);
      pin(2, 1'b1);
      pin(2, 1'b0);
      wr(OFS_CTRL, 32'h0);
      pin(2, 1'b1);
      pin(1, 1'b0);
      pin(2, 1'b0);
      // both inverted, index source and single edge selections
      wr(OFS_POLARITY, 32'h0);
      wr(OFS_CTRL, 32'h1723);
      pin(2, 1'b1);
      pin(0, 1'b1);
      pin(0, 1'b0);
      wrap_up();
   end
endmodule : tb_dual_probe_position_latch
